/* rtl/afc_top.sv */
// How it works
// - Eight 16-bit setup registers, reset 0x0500
// - Any register write aborts and restarts sequence
// - Bit 15 selects direct sinc3 decimation
// - Direct rate is modulator rate over 32N
// - Reserved bits 14:12 and 7 read zero
// - Bit 11 enables the postfilter
// - Bits 10:8 pick one of four postfilters
// - Bits 6:5 select the filter order
// - Order 00 sinc5+sinc1, 11 sinc3
// - Bits 4:0 pick the output data rate
//
// Design decision made here: the APB interface to the registers.
`include "afc_defines.svh"
`default_nettype none
module afc_top #(
  parameter int unsigned SETTLE_27_CYCLES =
    `AFC_SETTLE_27_US * (`AFC_CLK_HZ / 1000000),
  parameter int unsigned SETTLE_25_CYCLES =
    `AFC_SETTLE_25_US * (`AFC_CLK_HZ / 1000000),
  parameter int unsigned SETTLE_20_CYCLES =
    `AFC_SETTLE_20_US * (`AFC_CLK_HZ / 1000000),
  parameter int unsigned SETTLE_16_CYCLES =
    `AFC_SETTLE_16_US * (`AFC_CLK_HZ / 1000000)
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [2:0] SETUP_SEL,
  input wire logic MOD_TICK,
  output logic CONV_RESTART,
  output logic RESULT_STROBE,
  output logic DIRECT_DECIM_MODE,
  output logic [14:0] DECIM_RATE,
  output logic POSTFILTER_ENABLE,
  output logic POSTFILTER_ACTIVE,
  output logic [2:0] POSTFILTER_SELECT,
  output logic POSTFILTER_CODE_LEGAL,
  output logic [1:0] FILTER_ORDER_SELECT,
  output logic SINC3_ORDER,
  output logic [4:0] OUTPUT_RATE_SELECT
);
  import afc_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Word aligned hit in the index window
  function automatic logic afc_hit(input logic [7:0] addr);
    afc_hit = (addr[1:0] == 2'h0) && (addr[7:2] >= `AFC_IDX_FIRST) &&
              (addr[7:2] <= `AFC_IDX_LAST);
  endfunction

  function automatic logic [2:0] afc_slot(input logic [7:0] addr);
    afc_slot = addr[4:2];
  endfunction

  // Period of one result, in ticks of whichever source is chosen
  function automatic logic [31:0] afc_pf_period(input logic [2:0] sel);
    case (sel)
      `AFC_PF_27SPS: afc_pf_period = 32'(SETTLE_27_CYCLES);
      `AFC_PF_25SPS: afc_pf_period = 32'(SETTLE_25_CYCLES);
      `AFC_PF_20SPS: afc_pf_period = 32'(SETTLE_20_CYCLES);
      `AFC_PF_16SPS: afc_pf_period = 32'(SETTLE_16_CYCLES);
      default: afc_pf_period = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [31:0] afc_odr_period(input logic [4:0] odr);
    if (odr <= `AFC_ODR_FAST_LAST) begin
      afc_odr_period = 32'(`AFC_ODR_FAST_TICKS);
    end else if (odr == `AFC_ODR_HALF) begin
      afc_odr_period = 32'(2 * `AFC_ODR_FAST_TICKS);
    end else begin
      afc_odr_period = 32'(`AFC_ODR_SLOW_TICKS);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  afc_top_type st_r;
  afc_top_type st_nxt;

  logic [15:0] sel_cfg;
  logic d_direct;
  logic [14:0] d_decim;
  logic d_pf_en;
  logic d_pf_active;
  logic [2:0] d_pf_sel;
  logic d_pf_legal;
  logic [1:0] d_order;
  logic d_sinc3;
  logic [4:0] d_odr;
  logic rg_tick;
  logic rg_strobe;

  assign sel_cfg = st_r.cfg[SETUP_SEL];

  afc_decode u_decode (
    .cfg(sel_cfg),
    .direct(d_direct),
    .decim(d_decim),
    .pf_en(d_pf_en),
    .pf_active(d_pf_active),
    .pf_sel(d_pf_sel),
    .pf_legal(d_pf_legal),
    .order(d_order),
    .sinc3(d_sinc3),
    .odr(d_odr)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.restart = 1'b0;

    // Zero wait states: ready is raised for the first access cycle
    if (PSEL && !PENABLE) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !afc_hit(PADDR);
      if (!PWRITE && afc_hit(PADDR)) begin
        st_nxt.prdata = {16'h0000, st_r.cfg[afc_slot(PADDR)]};
      end else begin
        st_nxt.prdata = 32'h0000_0000;
      end
    end else begin
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = 32'h0000_0000;
    end

    if (PSEL && PENABLE && st_r.pready && PWRITE && afc_hit(PADDR)) begin
      // Reserved bits are dropped so they always read back zero
      st_nxt.cfg[afc_slot(PADDR)] = PWDATA[15:0] & `AFC_WRITE_MASK;
      st_nxt.restart = 1'b1;
    end

    st_nxt.direct = d_direct;
    st_nxt.decim = d_decim;
    st_nxt.pf_en = d_pf_en;
    st_nxt.pf_active = d_pf_active;
    st_nxt.pf_sel = d_pf_sel;
    st_nxt.pf_legal = d_pf_legal;
    st_nxt.order = d_order;
    st_nxt.sinc3 = d_sinc3;
    st_nxt.odr = d_odr;

    // Direct mode counts modulator ticks, the postfilter counts REF_CLK
    if (d_direct) begin
      st_nxt.use_mod = 1'b1;
      st_nxt.period = 32'(`AFC_DIRECT_FACTOR) * {17'h00000, d_decim};
    end else if (d_pf_active) begin
      st_nxt.use_mod = 1'b0;
      // An unlisted code produces no results at all
      st_nxt.period = d_pf_legal ? afc_pf_period(d_pf_sel) : 32'h0000_0000;
    end else begin
      st_nxt.use_mod = 1'b1;
      st_nxt.period = afc_odr_period(d_odr);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r <= '0;
      st_r.cfg <= {8{`AFC_CFG_RESET}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Result timing
  // ----------------------------------------------------------------
  assign rg_tick = st_r.use_mod ? MOD_TICK : 1'b1;

  afc_rate_gen u_rate (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .tick(rg_tick),
    .period(st_r.period),
    .restart(st_r.restart),
    .strobe(rg_strobe)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PRDATA = st_r.prdata;
  assign PREADY = st_r.pready;
  assign PSLVERR = st_r.pslverr;
  assign CONV_RESTART = st_r.restart;
  assign RESULT_STROBE = rg_strobe;
  assign DIRECT_DECIM_MODE = st_r.direct;
  assign DECIM_RATE = st_r.decim;
  assign POSTFILTER_ENABLE = st_r.pf_en;
  assign POSTFILTER_ACTIVE = st_r.pf_active;
  assign POSTFILTER_SELECT = st_r.pf_sel;
  assign POSTFILTER_CODE_LEGAL = st_r.pf_legal;
  assign FILTER_ORDER_SELECT = st_r.order;
  assign SINC3_ORDER = st_r.sinc3;
  assign OUTPUT_RATE_SELECT = st_r.odr;

endmodule // afc_top
`default_nettype wire

/* rtl/afc_defines.svh */
`ifndef AFC_DEFINES_SVH
`define AFC_DEFINES_SVH

// ----------------------------------------------------------------
// Register map: printed offsets are word indices, byte address = 4 x index
// ----------------------------------------------------------------
`define AFC_IDX_FIRST 6'h28
`define AFC_IDX_LAST 6'h2F
`define AFC_CFG_RESET 16'h0500
`define AFC_WRITE_MASK 16'h8F7F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AFC_DIRECT_BIT 15
`define AFC_DECIM_MSB 14
`define AFC_PF_EN_BIT 11
`define AFC_PF_SEL_MSB 10
`define AFC_PF_SEL_LSB 8
`define AFC_ORDER_MSB 6
`define AFC_ORDER_LSB 5
`define AFC_ODR_MSB 4

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define AFC_PF_27SPS 3'h2
`define AFC_PF_25SPS 3'h3
`define AFC_PF_20SPS 3'h5
`define AFC_PF_16SPS 3'h6
`define AFC_ORDER_SINC5 2'h0
`define AFC_ORDER_SINC3 2'h3
`define AFC_ODR_FAST_LAST 5'h05
`define AFC_ODR_HALF 5'h06

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AFC_DIRECT_FACTOR 32
`define AFC_CLK_HZ 20000000
`define AFC_SETTLE_27_US 36700
`define AFC_SETTLE_25_US 40000
`define AFC_SETTLE_20_US 50000
`define AFC_SETTLE_16_US 60000
`define AFC_ODR_FAST_TICKS 32
`define AFC_ODR_SLOW_TICKS 192

`endif

/* rtl/afc_pkg.sv */
`default_nettype none
package afc_pkg;

  typedef enum logic [1:0] {
    AFC_RG_IDLE = 2'b01,
    AFC_RG_RUN = 2'b10
  } afc_rg_state_type;

  typedef struct packed {
    afc_rg_state_type state;
    logic [31:0] cnt;
    logic strobe;
  } afc_rg_type;

  typedef struct packed {
    logic [7:0][15:0] cfg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic restart;
    logic direct;
    logic [14:0] decim;
    logic pf_en;
    logic pf_active;
    logic [2:0] pf_sel;
    logic pf_legal;
    logic [1:0] order;
    logic sinc3;
    logic [4:0] odr;
    logic [31:0] period;
    logic use_mod;
  } afc_top_type;

endpackage
`default_nettype wire

/* rtl/afc_decode.sv */
`include "afc_defines.svh"
`default_nettype none
module afc_decode (
  input wire logic [15:0] cfg,
  output logic direct,
  output logic [14:0] decim,
  output logic pf_en,
  output logic pf_active,
  output logic [2:0] pf_sel,
  output logic pf_legal,
  output logic [1:0] order,
  output logic sinc3,
  output logic [4:0] odr
);
  import afc_pkg::*;

  always_comb begin
    direct = cfg[`AFC_DIRECT_BIT];
    // Direct mode reuses the low bits as the decimation value
    decim = direct ? cfg[`AFC_DECIM_MSB:0] : 15'h0000;
    // Every other option is forced off while in direct mode
    pf_en = !direct && cfg[`AFC_PF_EN_BIT];
    pf_sel = direct ? 3'h0 : cfg[`AFC_PF_SEL_MSB:`AFC_PF_SEL_LSB];
    order = direct ? 2'h0 : cfg[`AFC_ORDER_MSB:`AFC_ORDER_LSB];
    sinc3 = !direct && (order == `AFC_ORDER_SINC3);
    odr = direct ? 5'h00 : cfg[`AFC_ODR_MSB:0];
    // The postfilter only works behind the sinc5 + sinc1 path
    pf_active = pf_en && (order == `AFC_ORDER_SINC5);
    case (pf_sel)
      `AFC_PF_27SPS,
      `AFC_PF_25SPS,
      `AFC_PF_20SPS,
      `AFC_PF_16SPS: pf_legal = 1'b1;
      default: pf_legal = 1'b0;
    endcase
  end

endmodule // afc_decode
`default_nettype wire

/* rtl/afc_rate_gen.sv */
`default_nettype none
module afc_rate_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [31:0] period,
  input wire logic restart,
  output logic strobe
);
  import afc_pkg::*;

  afc_rg_type st_r;
  afc_rg_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.strobe = 1'b0;
    case (st_r.state)
      AFC_RG_IDLE: begin
        st_nxt.cnt = 32'h0000_0000;
        if (period != 32'h0000_0000) begin
          st_nxt.state = AFC_RG_RUN;
        end
      end
      AFC_RG_RUN: begin
        if (period == 32'h0000_0000) begin
          st_nxt.state = AFC_RG_IDLE;
        end else if (tick) begin
          if (st_r.cnt + 32'h0000_0001 >= period) begin
            st_nxt.cnt = 32'h0000_0000;
            st_nxt.strobe = 1'b1;
          end else begin
            st_nxt.cnt = st_r.cnt + 32'h0000_0001;
          end
        end
      end
      default: st_nxt.state = AFC_RG_IDLE;
    endcase
    // Abort wins over a result due in the same cycle
    if (restart) begin
      st_nxt.state = AFC_RG_IDLE;
      st_nxt.cnt = 32'h0000_0000;
      st_nxt.strobe = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{state: AFC_RG_IDLE, cnt: 32'h0000_0000, strobe: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign strobe = st_r.strobe;

endmodule // afc_rate_gen
`default_nettype wire

/* verification/afc_top_monitor.sv */
`default_nettype none
module afc_top_monitor (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CONV_RESTART,
  input wire logic DIRECT_DECIM_MODE,
  input wire logic POSTFILTER_ENABLE,
  input wire logic POSTFILTER_ACTIVE,
  input wire logic [1:0] FILTER_ORDER_SELECT,
  input wire logic SINC3_ORDER,
  input wire logic [4:0] OUTPUT_RATE_SELECT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_ready_once; PREADY |=> !PREADY; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  property p_restart; PSEL && PENABLE && PREADY && PWRITE && !PSLVERR |=> CONV_RESTART;
  endproperty
  a_restart: assert property (p_restart) else $error("write without restart");
  property p_restart_cause;
    CONV_RESTART |-> $past(PSEL && PENABLE && PWRITE && !PSLVERR);
  endproperty
  a_restart_cause: assert property (p_restart_cause) else $error("stray restart");
  property p_reserved;
    PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0 && PRDATA[14:12] == 3'h0 && !PRDATA[7];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
  property p_direct;
    DIRECT_DECIM_MODE |-> !POSTFILTER_ENABLE && FILTER_ORDER_SELECT == 2'h0
      && OUTPUT_RATE_SELECT == 5'h00;
  endproperty
  a_direct: assert property (p_direct) else $error("options kept in direct mode");
  property p_sinc3; SINC3_ORDER == (FILTER_ORDER_SELECT == 2'h3); endproperty
  a_sinc3: assert property (p_sinc3) else $error("order decode wrong");
  property p_pf_active;
    POSTFILTER_ACTIVE |-> POSTFILTER_ENABLE && FILTER_ORDER_SELECT == 2'h0;
  endproperty
  a_pf_active: assert property (p_pf_active) else $error("postfilter active wrongly");
endmodule // afc_top_monitor

bind afc_top afc_top_monitor i_mon (.REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CONV_RESTART(CONV_RESTART), .DIRECT_DECIM_MODE(DIRECT_DECIM_MODE),
  .POSTFILTER_ENABLE(POSTFILTER_ENABLE), .POSTFILTER_ACTIVE(POSTFILTER_ACTIVE),
  .FILTER_ORDER_SELECT(FILTER_ORDER_SELECT), .SINC3_ORDER(SINC3_ORDER),
  .OUTPUT_RATE_SELECT(OUTPUT_RATE_SELECT));
`default_nettype wire

/* verification/afc_top_test.sv */
`default_nettype none
module afc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, tick = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, restart, strobe, dmode, pfen, pfact, legal, s3;
  logic [2:0] sel = 3'h3, pfsel;
  logic [14:0] decim;
  logic [1:0] ord;
  logic [4:0] odr;
  // Host side keeps order 00 and uses listed codes whenever the postfilter is enabled
  logic [15:0] cfgs [9] = '{16'h8123, 16'h0A00, 16'h0B00, 16'h0D00, 16'h0E00,
    16'h0200, 16'h0066, 16'h0026, 16'h0500};
  int n_mismatch = 0, num_checks = 0;
  always #25 clk = ~clk;
  // Modulator tick every second cycle, so N ticks span 2N cycles
  always @(posedge clk) tick <= ~tick;

  afc_top #(.SETTLE_20_CYCLES(24)) i_dut (.REF_CLK(clk), .RESETN(rst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SETUP_SEL(sel), .MOD_TICK(tick),
    .CONV_RESTART(restart), .RESULT_STROBE(strobe), .DIRECT_DECIM_MODE(dmode),
    .DECIM_RATE(decim), .POSTFILTER_ENABLE(pfen), .POSTFILTER_ACTIVE(pfact),
    .POSTFILTER_SELECT(pfsel), .POSTFILTER_CODE_LEGAL(legal), .FILTER_ORDER_SELECT(ord),
    .SINC3_ORDER(s3), .OUTPUT_RATE_SELECT(odr));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Request stands until ready is seen high at a rising edge
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] i, input logic [15:0] d, input logic ok);
    apb(1'b1, {i, 2'b00}, {16'h0, d});
    @(negedge clk);
    chk({31'h0, restart}, {31'h0, ok});
  endtask

  task automatic rdchk(input logic [5:0] i, input logic [31:0] exp);
    apb(1'b0, {i, 2'b00}, 32'h0);
    chk(rd, exp);
  endtask

  function automatic logic [29:0] dec(input logic [15:0] c);
    return c[15] ? {1'b1, c[14:0], 14'h0} : {16'h0, c[11], c[11] && c[6:5] == 2'h0,
      c[10:8], c[10:8] inside {3'h2, 3'h3, 3'h5, 3'h6}, c[6:5], c[6:5] == 2'h3, c[4:0]};
  endfunction

  task automatic dchk(input logic [15:0] c);
    chk({2'h0, dmode, decim, pfen, pfact, pfsel, legal, ord, s3, odr}, {2'h0, dec(c)});
  endtask

  // Distance in cycles between two consecutive result strobes
  task automatic per(input logic [15:0] c, input int exp);
    int n;
    wr(6'h2B, c, 1'b1);
    n = 1;
    while (strobe !== 1'b1) @(negedge clk);
    @(negedge clk);
    while (strobe !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    chk(n, exp);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk(6'h28 + i, 32'h0500);
    for (int i = 0; i < 8; i++) begin
      wr(6'h28 + i, 16'hFFFF - i, 1'b1);
      rdchk(6'h28 + i, 32'h8F7F & (32'hFFFF - i));
    end
    wr(6'h30, 16'h0, 1'b0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'hA2, 32'h0);
    chk({31'h0, err}, 32'h1);
    foreach (cfgs[j]) begin
      wr(6'h2B, cfgs[j], 1'b1);
      @(negedge clk);
      dchk(cfgs[j]);
    end
    @(posedge clk);
    sel <= 3'h4;
    repeat (2) @(negedge clk);
    dchk(16'h8F7B);
    @(posedge clk);
    sel <= 3'h3;
    per(16'h8002, 128);
    per(16'h0000, 64);
    per(16'h0006, 128);
    per(16'h0D00, 24);
    tally_and_finish();
  end

  // Whole run is well under 100 us; a hang ends here
  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // afc_top_test
`default_nettype wire
